/* File: logic/iom_pkg.sv */
// Package with opcodes, widths, reset values and the instruction struct for the execute datapath
package iom_pkg;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FADDR_W    = 7;
   localparam logic [7:0]  ACC_RST    = 8'h00;
   localparam logic [7:0]  FILE_RST   = 8'h00;
   localparam logic        ZERO_RST   = 1'b0;
   localparam logic        DEST_ACC   = 1'b0;
   localparam logic        DEST_FILE  = 1'b1;
   localparam logic [7:0]  INC_STEP   = 8'h01;
   localparam int unsigned FILE_DEPTH = 128;

   // Operation codes presented by the decoder
   typedef enum logic [2:0] {
      IOM_OP_NONE                        = 3'b000,
      IOM_OP_INCREMENT_SKIP_ON_NULL      = 3'b001,
      IOM_OP_OR_LITERAL_INTO_ACCUMULATOR = 3'b010,
      IOM_OP_OR_ACCUMULATOR_WITH_FILE    = 3'b011,
      IOM_OP_INCREMENT_FILE              = 3'b100,
      IOM_OP_COPY_FILE                   = 3'b101
   } iom_op_e;

   // One instruction as handed to the datapath
   typedef struct packed {
      iom_op_e              op;
      logic [FADDR_W-1:0]   faddr;
      logic                 dest;
      logic [DATA_W-1:0]    literal;
   } iom_instr_s;

   // Execute state: normal issue or forced idle cycle after a skip
   typedef enum logic [0:0] {
      IOM_ST_RUN  = 1'b0,
      IOM_ST_IDLE = 1'b1
   } iom_state_e;
endpackage : iom_pkg

/* File: logic/iom_exec.sv */
// Execute datapath for increment, increment-skip, OR and copy instructions
`timescale 1ns/1ps

// Function
// - Destination bit: 0 accumulator, 1 file
// - Increment-skip: no flags, idle cycle if zero
// - OR literal into accumulator, update zero
// - OR accumulator with file, update zero
// - Increment file, update zero, never skip
// - Copy file to destination, update zero
module iom_exec
   import iom_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                instr_valid,
   input  wire iom_instr_s          instr,
   output logic                     instr_ready,
   output logic [DATA_W-1:0]        accumulator,
   output logic                     zero_flag,
   output logic                     skip_idle,
   output logic                     retire
);
   // Timing: an instruction is taken at a rising edge that sees valid, ready
   // and the run state; its result, zero flag and retire pulse show after that
   // same edge. The file array is read combinationally, so a write-back made by
   // one instruction is seen by the instruction taken at the following edge.
   // Hazard: a zero-result increment-skip forces one idle cycle in which ready
   // is low and whatever is offered is ignored; the caller must hold it.

   // Reset synchroniser and its released copy
   logic [1:0]           rst_sync_r;
   logic                 rst_n_i;

   // Architectural state: file array, accumulator and zero flag
   logic [DATA_W-1:0]    file_mem [FILE_DEPTH];
   logic [DATA_W-1:0]    acc_r;
   logic [DATA_W-1:0]    acc_nxt;
   logic                 zero_r;
   logic                 zero_nxt;

   // Sequencing state and one-cycle strobes
   iom_state_e           state_r;
   iom_state_e           state_nxt;
   logic                 skip_r;
   logic                 skip_nxt;
   logic                 retire_r;
   logic                 retire_nxt;
   logic                 ready_r;
   logic                 ready_nxt;

   // Decoded instruction class and issue qualifier
   logic                 is_skip;
   logic                 is_inc;
   logic                 is_orl;
   logic                 is_orf;
   logic                 is_copy;
   logic                 is_known;
   logic                 in_run;
   logic                 take;

   // Operands and candidate results
   logic [DATA_W-1:0]    file_val;
   logic [DATA_W-1:0]    inc_val;
   logic [DATA_W-1:0]    orl_val;
   logic [DATA_W-1:0]    orf_val;
   logic [DATA_W-1:0]    result;
   logic                 res_zero;

   // Write enables and control strobes
   logic                 upd_zero;
   logic                 to_file;
   logic                 to_acc;
   logic                 do_skip;

   // Reset release through two flip-flops; deassertion is synchronous to clock
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'h1};
      end
   end

   // Only the second flip-flop drives the released reset
   assign rst_n_i = rst_sync_r[1];

   // Opcode decode; the empty code and the spare codes match nothing
   // Fields that an operation does not use are don't-care for it
   assign is_skip  = (instr.op == IOM_OP_INCREMENT_SKIP_ON_NULL);
   assign is_inc   = (instr.op == IOM_OP_INCREMENT_FILE);
   assign is_orl   = (instr.op == IOM_OP_OR_LITERAL_INTO_ACCUMULATOR);
   assign is_orf   = (instr.op == IOM_OP_OR_ACCUMULATOR_WITH_FILE);
   assign is_copy  = (instr.op == IOM_OP_COPY_FILE);
   assign is_known = is_skip || is_inc || is_orl || is_orf || is_copy;

   // Issue qualifier: take only in the run state while ready is shown
   assign in_run = (state_r == IOM_ST_RUN);
   assign take   = instr_valid && ready_r && in_run;

   // Operand read by file address, combinational
   assign file_val = file_mem[instr.faddr];

   // Candidate results of the increment and OR paths
   assign inc_val  = file_val + INC_STEP;
   assign orl_val  = acc_r | instr.literal;
   assign orf_val  = acc_r | file_val;

   // Result selection; copy passes the file value through unchanged
   // The increment carry out of bit 7 is dropped, so 8'hFF wraps to zero
   assign result   = (is_skip || is_inc) ? inc_val :
                     is_orl              ? orl_val :
                     is_orf              ? orf_val :
                                           file_val;

   // Zero detect on the eight-bit result
   assign res_zero = (result == '0);

   // Zero flag is written by every known op except increment-skip
   assign upd_zero = take && (is_inc || is_orl || is_orf || is_copy);

   // Literal form always targets the accumulator; the others follow the bit
   assign to_file  = take && is_known && !is_orl && (instr.dest == DEST_FILE);
   assign to_acc   = take && is_known && (is_orl || (instr.dest == DEST_ACC));

   // Skip only on a zero result of increment-skip; plain increment never skips
   assign do_skip  = take && is_skip && res_zero;

   // Next accumulator and zero flag
   assign acc_nxt  = to_acc ? result : acc_r;
   assign zero_nxt = upd_zero ? res_zero : zero_r;

   // Sequencer: one idle cycle takes the place of the next instruction
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         IOM_ST_RUN: begin
            if (do_skip) begin
               state_nxt = IOM_ST_IDLE;
            end else begin
               state_nxt = IOM_ST_RUN;
            end
         end
         IOM_ST_IDLE: begin
            state_nxt = IOM_ST_RUN;
         end
      endcase
   end

   // Strobes for the next cycle; ready drops for the idle cycle only
   assign skip_nxt   = do_skip;
   assign retire_nxt = take && is_known;
   assign ready_nxt  = (state_nxt == IOM_ST_RUN);

   // Accumulator
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_r <= ACC_RST;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // Zero flag
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zero_r <= ZERO_RST;
      end else begin
         zero_r <= zero_nxt;
      end
   end

   // Execute state
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= IOM_ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Skip-idle pulse, high during the idle cycle
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         skip_r <= 1'h0;
      end else begin
         skip_r <= skip_nxt;
      end
   end

   // Retire pulse, one cycle after a known instruction is taken
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         retire_r <= 1'h0;
      end else begin
         retire_r <= retire_nxt;
      end
   end

   // Issue ready; low out of reset until the first released edge
   always_ff @(posedge clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_r <= 1'h0;
      end else begin
         ready_r <= ready_nxt;
      end
   end

   // File register array write-back; storage has no reset
   always_ff @(posedge clock) begin
      if (to_file) begin
         file_mem[instr.faddr] <= result;
      end
   end

   // Outputs come straight from the flip-flops
   assign accumulator = acc_r;
   assign zero_flag   = zero_r;
   assign skip_idle   = skip_r;
   assign retire      = retire_r;
   assign instr_ready = ready_r;
endmodule : iom_exec

/* File: tb/iom_checker.sv */
// Port assertions for the execute datapath, bound into iom_exec
`timescale 1ns/1ps
module iom_checker
   import iom_pkg::*;
(
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       instr_valid,
   input wire iom_instr_s instr,
   input wire logic       instr_ready,
   input wire logic [7:0] accumulator,
   input wire logic       zero_flag,
   input wire logic       skip_idle,
   input wire logic       retire
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Classes of taken instructions
   wire t   = instr_valid && instr_ready;
   wire lit = t && instr.op == IOM_OP_OR_LITERAL_INTO_ACCUMULATOR;
   wire fop = t && instr.op inside {[IOM_OP_OR_ACCUMULATOR_WITH_FILE:IOM_OP_COPY_FILE]};
   wire orf = fop && instr.op == IOM_OP_OR_ACCUMULATOR_WITH_FILE && !instr.dest;
   wire skp = t && instr.op == IOM_OP_INCREMENT_SKIP_ON_NULL;
   sequence s_idle; skip_idle && !instr_ready ##1 instr_ready && !skip_idle; endsequence
   property p_lit; lit |=> accumulator == ($past(accumulator) | $past(instr.literal)); endproperty
   a_lit: assert property (p_lit) else $error("or literal wrong");
   property p_zero; lit || fop && !instr.dest |=> zero_flag == (accumulator == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_skz; skp |=> $stable(zero_flag); endproperty
   a_skz: assert property (p_skz) else $error("skip changed flag");
   property p_idle; skip_idle |-> s_idle; endproperty
   a_idle: assert property (p_idle) else $error("idle cycle wrong");
   property p_nop; skip_idle |=> !retire; endproperty
   a_nop: assert property (p_nop) else $error("idle cycle retired");
   property p_inc; t && instr.op == IOM_OP_INCREMENT_FILE |=> !skip_idle; endproperty
   a_inc: assert property (p_inc) else $error("increment skipped");
   property p_dest; fop && instr.dest |=> $stable(accumulator); endproperty
   a_dest: assert property (p_dest) else $error("accumulator written");
   property p_orf; orf |=> (accumulator & $past(accumulator)) == $past(accumulator); endproperty
   a_orf: assert property (p_orf) else $error("or file lost bits");
endmodule : iom_checker
bind iom_exec iom_checker u_chk (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .accumulator(accumulator), .zero_flag(zero_flag),
   .skip_idle(skip_idle), .retire(retire));

/* File: tb/testbench.sv */
// Directed testbench for the execute datapath
`timescale 1ns/1ps
module testbench
   import iom_pkg::*;
   ;
   logic clock = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
   logic instr_ready, zero_flag, skip_idle, retire;
   iom_instr_s instr = '0;
   logic [7:0] accumulator;
   int fail_count = 0, n_checks = 0;
   localparam iom_op_e SK = IOM_OP_INCREMENT_SKIP_ON_NULL, LI = IOM_OP_OR_LITERAL_INTO_ACCUMULATOR;
   localparam iom_op_e OF = IOM_OP_OR_ACCUMULATOR_WITH_FILE, CP = IOM_OP_COPY_FILE;
   iom_exec dut (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
                 .instr_ready(instr_ready), .accumulator(accumulator), .zero_flag(zero_flag),
                 .skip_idle(skip_idle), .retire(retire));
   always #50 clock = ~clock;
   task automatic chk(logic [8:0] seen, logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One instruction, then zero flag and accumulator a cycle later
   task automatic ex(iom_op_e o, logic [6:0] f, logic d, logic [7:0] k, logic [8:0] e);
      @(negedge clock);
      instr_valid = 1'b1;
      instr = '{o, f, d, k};
      @(negedge clock);
      instr_valid = 1'b0;
      chk({zero_flag, accumulator}, e);
   endtask : ex
   // Literal OR, file OR, increment, copy and a refused code
   task automatic t_file();
      ex(LI, 7'h00, 1'b0, 8'h00, 9'h100);
      chk({8'h00, retire}, 9'h001);
      ex(LI, 7'h00, 1'b1, 8'hA5, 9'h0A5);
      ex(LI, 7'h00, 1'b0, 8'h5A, 9'h0FF);
      ex(OF, 7'h03, 1'b1, 8'h00, 9'h0FF);
      ex(IOM_OP_INCREMENT_FILE, 7'h03, 1'b1, 8'h00, 9'h1FF);
      chk({8'h00, skip_idle}, 9'h000);
      ex(CP, 7'h03, 1'b1, 8'h00, 9'h1FF);
      ex(IOM_OP_INCREMENT_FILE, 7'h03, 1'b0, 8'h00, 9'h001);
      ex(CP, 7'h03, 1'b0, 8'h00, 9'h100);
      ex(IOM_OP_INCREMENT_FILE, 7'h03, 1'b1, 8'h00, 9'h000);
      ex(OF, 7'h03, 1'b0, 8'h00, 9'h001);
      ex(IOM_OP_NONE, 7'h03, 1'b1, 8'hFF, 9'h001);
      chk({8'h00, retire}, 9'h000);
      $display("file test done");
   endtask : t_file
   // Increment-skip on zero and non-zero results, with the idle cycle
   task automatic t_skip();
      ex(LI, 7'h00, 1'b0, 8'hFF, 9'h0FF);
      ex(OF, 7'h03, 1'b1, 8'h00, 9'h0FF);
      ex(SK, 7'h03, 1'b1, 8'h00, 9'h0FF);
      chk({6'h00, skip_idle, instr_ready, retire}, 9'h005);
      @(negedge clock);
      chk({6'h00, skip_idle, instr_ready, retire}, 9'h002);
      ex(CP, 7'h03, 1'b0, 8'h00, 9'h100);
      ex(SK, 7'h03, 1'b0, 8'h00, 9'h101);
      chk({6'h00, skip_idle, instr_ready, retire}, 9'h003);
      $display("skip test done");
   endtask : t_skip
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Reset, tests, then a watchdog well past the expected run
   initial begin
      repeat (16) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      t_file();
      t_skip();
      end_of_test();
   end
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
endmodule : testbench
